/* File: design/gpit_pkg.sv */
// shared constants and types for the gated prescaled interval timer
package gpit_pkg;

	// register indices on the plain register port
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_COUNT = 3'h1;
	localparam logic [2:0] ADDR_PERIOD = 3'h2;
	localparam logic [2:0] ADDR_STATUS = 3'h3;
	localparam logic [2:0] ADDR_MASK = 3'h4;

	// control register field positions
	localparam int CTRL_RUN_BIT = 15;
	localparam int CTRL_IDLE_BIT = 13;
	localparam int CTRL_EXT_LSB = 8;
	localparam int CTRL_GATE_BIT = 6;
	localparam int CTRL_PRE_LSB = 4;
	localparam int CTRL_SYNC_BIT = 2;
	localparam int CTRL_SRC_BIT = 1;
	localparam logic [15:0] CTRL_RSVD_MASK = 16'h5C89;

	// status and mask bit positions
	localparam int STAT_MATCH_BIT = 0;
	localparam int STAT_GATE_BIT = 1;
	localparam int STAT_WIDTH = 2;

	// reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
	localparam logic [1:0] STAT_RESET = 2'h0;

	// extended source codes
	localparam logic [1:0] EXT_SECONDARY = 2'h0;
	localparam logic [1:0] EXT_PIN = 2'h1;
	localparam logic [1:0] EXT_LOW_POWER_RC_OSC = 2'h2;

	// prescale terminal counts for 1:1, 1:8, 1:64, 1:256
	localparam logic [7:0] PRE_LIM_1 = 8'h00;
	localparam logic [7:0] PRE_LIM_8 = 8'h07;
	localparam logic [7:0] PRE_LIM_64 = 8'h3F;
	localparam logic [7:0] PRE_LIM_256 = 8'hFF;

	typedef struct packed {
		logic run;
		logic idle_halt_select;
		logic [1:0] ext_source_select;
		logic gate_accum_enable;
		logic [1:0] prescale_select;
		logic ext_input_sync;
		logic source_select;
	} gpit_ctrl_s;

	typedef enum logic [1:0] {
		GPIT_OFF = 2'b00,
		GPIT_TIMER = 2'b01,
		GPIT_GATED = 2'b11,
		GPIT_COUNTER = 2'b10
	} gpit_mode_e;

endpackage

/* File: design/gpit_edge.sv */
// edge detector for an external level, optionally double-synchronised
`timescale 1ns/1ps
`default_nettype none
module gpit_edge (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic level,
	input wire logic use_sync,
	output logic rise,
	output logic fall
);
	logic meta;
	logic sync_q;
	logic direct_q;
	logic prev;
	logic cur;

	// the direct path saves one cycle of latency but trusts the pin timing
	assign cur = use_sync ? sync_q : direct_q;
	assign rise = cur & ~prev;
	assign fall = ~cur & prev;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta <= 1'b0;
			sync_q <= 1'b0;
			direct_q <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= level;
			sync_q <= meta;
			direct_q <= level;
			prev <= cur;
		end
	end
endmodule
`default_nettype wire

/* File: design/gpit_prescaler.sv */
// programmable prescaler: passes one tick out of 1, 8, 64 or 256
`timescale 1ns/1ps
`default_nettype none
module gpit_prescaler (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [1:0] ratio,
	output logic tick_out
);
	logic [7:0] cnt;
	logic [7:0] limit;
	logic at_limit;

	function automatic logic [7:0] ratio_limit(input logic [1:0] sel);
		case (sel)
			2'd0: ratio_limit = gpit_pkg::PRE_LIM_1;
			2'd1: ratio_limit = gpit_pkg::PRE_LIM_8;
			2'd2: ratio_limit = gpit_pkg::PRE_LIM_64;
			default: ratio_limit = gpit_pkg::PRE_LIM_256;
		endcase
	endfunction

	assign limit = ratio_limit(ratio);
	assign at_limit = (cnt >= limit);
	assign tick_out = tick_in & at_limit;

	always_ff @(posedge clock) begin
		if (sys_rst || clear) begin
			cnt <= 8'h00;
		end else if (tick_in) begin
			cnt <= at_limit ? 8'h00 : cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* File: design/gpit_timer.sv */
// top of the gated prescaled interval timer with its register port
`timescale 1ns/1ps
`default_nettype none
module gpit_timer (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic ext_count_pin,
	input wire logic secondary_osc,
	input wire logic low_power_rc_osc,
	input wire logic cpu_idle,
	input wire logic cpu_sleep,
	output logic irq
);
	gpit_pkg::gpit_ctrl_s ctrl;
	gpit_pkg::gpit_mode_e mode;
	logic [15:0] count;
	logic [15:0] period_value;
	logic [1:0] status;
	logic [1:0] mask;
	logic [15:0] ctrl_word;
	logic [15:0] next_rdata;
	logic [1:0] next_status;
	logic [15:0] next_count;

	// address decode
	wire wr_ctrl = reg_wr && (reg_addr == gpit_pkg::ADDR_CTRL);
	wire wr_count = reg_wr && (reg_addr == gpit_pkg::ADDR_COUNT);
	wire wr_period = reg_wr && (reg_addr == gpit_pkg::ADDR_PERIOD);
	wire wr_status = reg_wr && (reg_addr == gpit_pkg::ADDR_STATUS);
	wire wr_mask = reg_wr && (reg_addr == gpit_pkg::ADDR_MASK);

	// mode decode: gate enable only counts with the internal source
	assign mode = !ctrl.run ? gpit_pkg::GPIT_OFF :
		ctrl.source_select ? gpit_pkg::GPIT_COUNTER :
		ctrl.gate_accum_enable ? gpit_pkg::GPIT_GATED :
		gpit_pkg::GPIT_TIMER;

	// external source selection, reserved code selects nothing
	wire ext_level = (ctrl.ext_source_select == gpit_pkg::EXT_SECONDARY) ? secondary_osc :
		(ctrl.ext_source_select == gpit_pkg::EXT_PIN) ? ext_count_pin :
		(ctrl.ext_source_select == gpit_pkg::EXT_LOW_POWER_RC_OSC) ? low_power_rc_osc : 1'b0;

	wire ext_rise;
	wire gate_fall;

	// sync choice only matters for the external source
	gpit_edge u_ext_edge (
		.clock(clock),
		.sys_rst(sys_rst),
		.level(ext_level),
		.use_sync(ctrl.ext_input_sync),
		.rise(ext_rise),
		.fall()
	);

	// gate is the count pin, always synchronised
	gpit_edge u_gate_edge (
		.clock(clock),
		.sys_rst(sys_rst),
		.level(ext_count_pin),
		.use_sync(1'b1),
		.rise(),
		.fall(gate_fall)
	);

	logic gate_meta;
	logic gate_level;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			gate_meta <= 1'b0;
			gate_level <= 1'b0;
		end else begin
			gate_meta <= ext_count_pin;
			gate_level <= gate_meta;
		end
	end

	// the system clock stands for the half-oscillator internal clock
	wire src_tick = ctrl.source_select ? ext_rise : 1'b1;
	// only the direct external path keeps counting in sleep
	wire sleep_stop = cpu_sleep && !(ctrl.source_select && !ctrl.ext_input_sync);
	wire idle_stop = cpu_idle && ctrl.idle_halt_select;
	wire gate_ok = (mode != gpit_pkg::GPIT_GATED) || gate_level;
	wire count_en = (mode != gpit_pkg::GPIT_OFF) && !sleep_stop && !idle_stop && gate_ok;

	wire count_tick;
	gpit_prescaler u_pre (
		.clock(clock),
		.sys_rst(sys_rst),
		.clear(!ctrl.run),
		.tick_in(src_tick && count_en),
		.ratio(ctrl.prescale_select),
		.tick_out(count_tick)
	);

	wire match_hit = count_tick && (count == period_value);
	wire gate_evt = gate_fall && (mode == gpit_pkg::GPIT_GATED) && !idle_stop;

	// a software write to the count takes priority over counting
	always_comb begin
		next_count = count;
		if (wr_count) begin
			next_count = reg_wdata;
		end else if (match_hit) begin
			next_count = gpit_pkg::COUNT_RESET;
		end else if (count_tick) begin
			next_count = count + 16'h0001;
		end
	end

	// hardware set wins over a write-one clear in the same cycle
	always_comb begin
		next_status = status;
		if (wr_status) begin
			next_status = status & ~reg_wdata[gpit_pkg::STAT_WIDTH-1:0];
		end
		if (match_hit) begin
			next_status[gpit_pkg::STAT_MATCH_BIT] = 1'b1;
		end
		if (gate_evt) begin
			next_status[gpit_pkg::STAT_GATE_BIT] = 1'b1;
		end
	end

	// unimplemented bits are never stored, so they read as zero
	assign ctrl_word = {ctrl.run, 1'b0, ctrl.idle_halt_select, 3'b000,
		ctrl.ext_source_select, 1'b0, ctrl.gate_accum_enable,
		ctrl.prescale_select, 1'b0, ctrl.ext_input_sync,
		ctrl.source_select, 1'b0};

	always_comb begin
		if (reg_addr == gpit_pkg::ADDR_CTRL) begin
			next_rdata = ctrl_word;
		end else if (reg_addr == gpit_pkg::ADDR_COUNT) begin
			next_rdata = count;
		end else if (reg_addr == gpit_pkg::ADDR_PERIOD) begin
			next_rdata = period_value;
		end else if (reg_addr == gpit_pkg::ADDR_STATUS) begin
			next_rdata = {14'h0000, status};
		end else if (reg_addr == gpit_pkg::ADDR_MASK) begin
			next_rdata = {14'h0000, mask};
		end else begin
			next_rdata = 16'h0000;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl <= gpit_pkg::gpit_ctrl_s'(9'h000);
		end else if (wr_ctrl) begin
			ctrl.run <= reg_wdata[gpit_pkg::CTRL_RUN_BIT];
			ctrl.idle_halt_select <= reg_wdata[gpit_pkg::CTRL_IDLE_BIT];
			ctrl.ext_source_select <= reg_wdata[gpit_pkg::CTRL_EXT_LSB +: 2];
			ctrl.gate_accum_enable <= reg_wdata[gpit_pkg::CTRL_GATE_BIT];
			ctrl.prescale_select <= reg_wdata[gpit_pkg::CTRL_PRE_LSB +: 2];
			ctrl.ext_input_sync <= reg_wdata[gpit_pkg::CTRL_SYNC_BIT];
			ctrl.source_select <= reg_wdata[gpit_pkg::CTRL_SRC_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count <= gpit_pkg::COUNT_RESET;
			period_value <= gpit_pkg::PERIOD_RESET;
			status <= gpit_pkg::STAT_RESET;
			mask <= gpit_pkg::STAT_RESET;
			reg_rdata <= 16'h0000;
		end else begin
			count <= next_count;
			status <= next_status;
			if (wr_period) begin
				period_value <= reg_wdata;
			end
			if (wr_mask) begin
				mask <= reg_wdata[gpit_pkg::STAT_WIDTH-1:0];
			end
			reg_rdata <= reg_rd ? next_rdata : 16'h0000;
		end
	end

	// interrupt enable lives in the mask; priority belongs to the controller
	assign irq = |(status & mask);

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_match;
		count_tick && !wr_count && (count == period_value);
	endsequence

	sequence s_wrapped;
		(count == 16'h0000) && status[gpit_pkg::STAT_MATCH_BIT];
	endsequence

	AST_MATCH_WRAP: assert property (s_match |=> s_wrapped)
		else $error("period match did not wrap count and set flag");

	AST_MATCH_IRQ: assert property (s_match ##1 mask[0] |-> irq)
		else $error("match with mask set did not raise irq");

	AST_STOPPED: assert property (!ctrl.run && !wr_count |=> $stable(count))
		else $error("count moved while run bit clear");

	AST_IDLE_HALT: assert property (cpu_idle && ctrl.idle_halt_select && !wr_count
		|=> count == $past(count))
		else $error("count moved in idle with halt selected");

	AST_GATE_FALL: assert property (gate_fall && mode == gpit_pkg::GPIT_GATED
		&& !idle_stop |=> status[gpit_pkg::STAT_GATE_BIT])
		else $error("gate falling edge did not set flag");

	AST_GATE_LOW: assert property (mode == gpit_pkg::GPIT_GATED && !gate_level
		&& !wr_count |=> $stable(count))
		else $error("gated count moved while gate low");

	AST_INT_STEP: assert property (mode == gpit_pkg::GPIT_TIMER
		&& ctrl.prescale_select == 2'd0
		&& !cpu_idle && !cpu_sleep && !wr_count && count != period_value
		|=> count == $past(count) + 16'h0001)
		else $error("internal 1:1 timer did not step by one");

	AST_RSVD_READ: assert property (reg_rd && reg_addr == gpit_pkg::ADDR_CTRL
		|=> (reg_rdata & gpit_pkg::CTRL_RSVD_MASK) == 16'h0000)
		else $error("unimplemented control bits read nonzero");

	AST_RESERVED_SRC: assert property (mode == gpit_pkg::GPIT_COUNTER
		&& ctrl.ext_source_select == 2'd3 && !wr_count |=> $stable(count))
		else $error("reserved source code produced counts");

	AST_STICKY: assert property (status[0] && !(wr_status && reg_wdata[0]) |=> status[0])
		else $error("match flag dropped without a clear");

	sequence s_slow_tick;
		count_tick && ctrl.prescale_select != 2'd0 && !wr_ctrl;
	endsequence

	// a divided tick restarts the prescaler, so the next clock cannot tick again
	AST_PRESCALE_GAP: assert property (s_slow_tick |=> !count_tick)
		else $error("prescaled tick repeated on the next clock");

	sequence s_count_read;
		reg_rd && reg_addr == gpit_pkg::ADDR_COUNT;
	endsequence

	AST_READ_COUNT: assert property (s_count_read |=> reg_rdata == $past(count))
		else $error("count read returned a wrong value");

	AST_COUNT_WRITE: assert property (wr_count |=> count == $past(reg_wdata))
		else $error("count write did not land");

	AST_PERIOD_WRITE: assert property (wr_period
		|=> period_value == $past(reg_wdata))
		else $error("period write did not land");

	AST_IRQ_MASKED: assert property (mask == 2'b00 |-> !irq)
		else $error("irq raised with every source masked");

	AST_GATE_IRQ: assert property (mask[gpit_pkg::STAT_GATE_BIT]
		&& status[gpit_pkg::STAT_GATE_BIT] |-> irq)
		else $error("gate flag with its mask set did not raise irq");

	AST_RUN_WRITE: assert property (wr_ctrl && reg_wdata[gpit_pkg::CTRL_RUN_BIT]
		|=> ctrl.run)
		else $error("run bit write did not land");

	AST_IDLE_RUN: assert property (mode == gpit_pkg::GPIT_TIMER && cpu_idle
		&& !ctrl.idle_halt_select && !cpu_sleep && ctrl.prescale_select == 2'd0
		&& !wr_count && count != period_value |=> count == $past(count) + 16'h0001)
		else $error("timer stopped in idle without halt selected");

	AST_GATE_IGNORED: assert property (ctrl.run && ctrl.source_select
		|-> mode == gpit_pkg::GPIT_COUNTER)
		else $error("gate enable acted on the external source");

	// the direct external path has no clock of its own to lose in sleep
	AST_SLEEP_STOP: assert property (cpu_sleep && !wr_count
		&& (!ctrl.source_select || ctrl.ext_input_sync) |=> $stable(count))
		else $error("synchronised or internal count moved in sleep");

	sequence s_async_sleep_edge;
		cpu_sleep && mode == gpit_pkg::GPIT_COUNTER && !ctrl.ext_input_sync && !idle_stop
			&& ctrl.prescale_select == 2'd0 && ext_rise
			&& !wr_count && count != period_value;
	endsequence

	AST_ASYNC_SLEEP: assert property (s_async_sleep_edge
		|=> count == $past(count) + 16'h0001)
		else $error("unsynchronised external count stopped in sleep");

	AST_STATUS_CLEAR: assert property (wr_status && !match_hit
		&& reg_wdata[gpit_pkg::STAT_MATCH_BIT] |=> !status[gpit_pkg::STAT_MATCH_BIT])
		else $error("write of one did not clear the match flag");
endmodule
`default_nettype wire

/* File: tb/gpit_timer_test.sv */
// self-checking testbench for the gated prescaled interval timer
`timescale 1ns/1ps
`default_nettype none
module test_gpit_timer;
	logic clock;
	logic sys_rst;
	logic reg_wr;
	logic reg_rd;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic ext_count_pin;
	logic secondary_osc;
	logic low_power_rc_osc;
	logic cpu_idle;
	logic cpu_sleep;
	logic irq;
	int err_count;
	int samples_checked;
	// pulses per source in one burst: secondary 2, pin 3, low-power rc 4, code 11 none
	logic [15:0] ext_exp [4] = '{16'h0002, 16'h0003, 16'h0004, 16'h0000};
	logic [15:0] pre_exp [4] = '{16'h0100, 16'h0020, 16'h0004, 16'h0001};

	gpit_timer gpit_timer_inst (
		.clock(clock),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.ext_count_pin(ext_count_pin),
		.secondary_osc(secondary_osc),
		.low_power_rc_osc(low_power_rc_osc),
		.cpu_idle(cpu_idle),
		.cpu_sleep(cpu_sleep),
		.irq(irq)
	);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic final_report();
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// sampled at the edge closing the answer cycle, so the registered data has settled
	task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		chk(reg_rdata, exp);
	endtask

	task automatic irq_chk(input logic [15:0] exp);
		@(posedge clock);
		chk({15'h0000, irq}, exp);
	endtask

	task automatic start(input logic [15:0] cfg, input logic idle, input logic sleep);
		@(posedge clock);
		cpu_idle <= idle;
		cpu_sleep <= sleep;
		wr(gpit_pkg::ADDR_COUNT, 16'h0000);
		wr(gpit_pkg::ADDR_CTRL, cfg);
	endtask

	// stopping first freezes the count, so the read is independent of read latency
	task automatic stop_chk(input logic [15:0] exp);
		wr(gpit_pkg::ADDR_CTRL, 16'h0000);
		rd_chk(gpit_pkg::ADDR_COUNT, exp);
	endtask

	// run bit stands high for exactly n count clocks
	task automatic run_for(input logic [15:0] cfg, input int n, input logic idle,
		input logic sleep, input logic [15:0] exp);
		start(cfg, idle, sleep);
		repeat (n - 2) @(posedge clock);
		stop_chk(exp);
	endtask

	task automatic pulses();
		for (int i = 0; i < 6; i++) begin
			@(posedge clock);
			secondary_osc <= (i < 2);
			ext_count_pin <= (i < 3);
			low_power_rc_osc <= (i < 4);
			repeat (4) @(posedge clock);
			secondary_osc <= 1'b0;
			ext_count_pin <= 1'b0;
			low_power_rc_osc <= 1'b0;
			repeat (3) @(posedge clock);
		end
		repeat (8) @(posedge clock);
	endtask

	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		ext_count_pin = 1'b0;
		secondary_osc = 1'b0;
		low_power_rc_osc = 1'b0;
		cpu_idle = 1'b0;
		cpu_sleep = 1'b0;
		err_count = 0;
		samples_checked = 0;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		rd_chk(gpit_pkg::ADDR_CTRL, gpit_pkg::CTRL_RESET);
		rd_chk(gpit_pkg::ADDR_COUNT, 16'h0000);
		rd_chk(gpit_pkg::ADDR_PERIOD, 16'hFFFF);
		rd_chk(gpit_pkg::ADDR_STATUS, 16'h0000);
		rd_chk(gpit_pkg::ADDR_MASK, 16'h0000);
		rd_chk(3'h5, 16'h0000);
		wr(gpit_pkg::ADDR_CTRL, 16'h7FFF);
		rd_chk(gpit_pkg::ADDR_CTRL, 16'h2376);
		for (int p = 0; p < 4; p++) begin
			run_for(16'h8000 | (16'(p) << 4), 256, 1'b0, 1'b0, pre_exp[p]);
		end
		wr(gpit_pkg::ADDR_PERIOD, 16'h0009);
		run_for(16'h8000, 25, 1'b0, 1'b0, 16'h0005);
		rd_chk(gpit_pkg::ADDR_STATUS, 16'h0001);
		irq_chk(16'h0000);
		wr(gpit_pkg::ADDR_MASK, 16'h0003);
		irq_chk(16'h0001);
		wr(gpit_pkg::ADDR_STATUS, 16'h0001);
		irq_chk(16'h0000);
		rd_chk(gpit_pkg::ADDR_STATUS, 16'h0000);
		run_for(16'h8000, 12, 1'b0, 1'b0, 16'h0002);
		irq_chk(16'h0001);
		wr(gpit_pkg::ADDR_STATUS, 16'h0001);
		wr(gpit_pkg::ADDR_PERIOD, 16'hFFFF);
		run_for(16'hA000, 20, 1'b1, 1'b0, 16'h0000);
		run_for(16'h8000, 20, 1'b1, 1'b0, 16'h0014);
		run_for(16'h8000, 20, 1'b0, 1'b1, 16'h0000);
		// gate bit set here as well: it must be ignored with the external source
		for (int s = 0; s < 4; s++) begin
			for (int c = 0; c < 4; c++) begin
				start(16'h8042 | (16'(c) << 8) | (16'(s % 2) << 2), 1'b0, s > 1);
				pulses();
				stop_chk((s == 3) ? 16'h0000 : ext_exp[c]);
			end
		end
		start(16'h8040, 1'b0, 1'b0);
		repeat (10) @(posedge clock);
		ext_count_pin <= 1'b1;
		repeat (20) @(posedge clock);
		ext_count_pin <= 1'b0;
		repeat (6) @(posedge clock);
		stop_chk(16'h0014);
		rd_chk(gpit_pkg::ADDR_STATUS, 16'h0002);
		irq_chk(16'h0001);
		final_report();
	end

	// whole sequence needs about 2400 cycles
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		final_report();
	end
endmodule
`default_nettype wire
